/* cas_defines.svh */
// timing constants and reset values for the conversion sequencer
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH

`define CAS_CLK_PERIOD_NS   10
`define CAS_US_NS           1000
`define CAS_US_CYCLES       (`CAS_US_NS / `CAS_CLK_PERIOD_NS)
`define CAS_NOV_GAP_NS      1000
`define CAS_NOV_GAP_CYCLES  ((`CAS_NOV_GAP_NS + `CAS_CLK_PERIOD_NS - 1) / `CAS_CLK_PERIOD_NS)
`define CAS_TABLE_WAIT_US   50
`define CAS_WAIT_STEP_US    50
`define CAS_WAIT_RST_CODE   4'h1
`define CAS_RATE_RST        5'h00
`define CAS_FILT_RST        3'h1
`define CAS_CHOP_OFF        2'h0
`define CAS_CHOP_ON         2'h1
`define CAS_ACX_2WIRE       2'h2
`define CAS_ACX_4WIRE       2'h3
`define CAS_FILT_FIR        3'h0
`define CAS_RATE_CODES      17

`endif

/* cas_pkg.sv */
// types shared by the conversion sequencer modules
package cas_pkg;

  typedef enum logic [1:0] {
    CAS_IDLE = 2'b00,
    CAS_RUN  = 2'b01
  } cas_state_e;

  typedef struct packed {
    logic [4:0] rate;
    logic [2:0] filter;
    logic [1:0] chop;
    logic [3:0] wait_code;
    logic       continuous;
  } cas_cfg_s;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } cas_gpio_s;

endpackage

/* cas_excite_drive.sv */
// non-overlapping bridge excitation drive pair
`timescale 1ns/1ps
`include "cas_defines.svh"

module cas_excite_drive (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // control
  input  wire logic enable_i,
  input  wire logic reversed_i,
  // drives
  output logic      excite_drive_a_o,
  output logic      excite_drive_b_o
);

  typedef struct packed {
    logic [7:0] gap;
    logic       a;
    logic       b;
    logic       phase;
    logic       busy;
  } cas_drv_s;

  cas_drv_s st;
  cas_drv_s next_st;

  always_comb begin
    next_st = st;
    if (!enable_i) begin
      next_st = '0;
    end else if (st.busy) begin
      if (st.gap == 8'h00) begin
        next_st.busy = 1'b0;
        next_st.a    = ~st.phase;
        next_st.b    = st.phase;
      end else begin
        next_st.gap = st.gap - 8'h01;
      end
    end else if ((reversed_i != st.phase) || (!st.a && !st.b)) begin
      // break before make: both off first
      next_st.a     = 1'b0;
      next_st.b     = 1'b0;
      next_st.phase = reversed_i;
      next_st.busy  = 1'b1;
      next_st.gap   = 8'(`CAS_NOV_GAP_CYCLES - 1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign excite_drive_a_o = st.a;
  assign excite_drive_b_o = st.b;

endmodule // cas_excite_drive

/* cas_conv_seq.sv */
// conversion sequencer: latency, start wait, chop and ac-excitation
`timescale 1ns/1ps
`include "cas_defines.svh"

// Overview of operation
// - first settled result after rate/filter latency
// - chop or excitation doubles first latency
// - chopped results spaced by chop-off latency
// - wait before first conversion and each chopped one, 50 us default
// - start wait adds onto conversion latency
// - chop inverts polarity every conversion
// - first chopped conversion withheld, kept operand
// - output half difference, normal phase positive
// - nulls kept, extra nulls at half rate
// - excitation follows phase, reference inverted reversed
// - excitation result subtracts normal and reversed
// - drives never active together, gap between
// - drives toggle once per conversion only
// - field 10 two-wire, 11 four-wire
// - pins 0/1 carry A/B, 2/3 repeat in four-wire, undriven in two-wire
// - excitation slows rate like chop mode
// - ready high at start, low with data
// - later results one period or latency apart
module cas_conv_seq (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // conversion start pin
  input  wire logic              start_pin_i,
  // configuration
  input  wire logic              cfg_load_i,
  input  wire cas_pkg::cas_cfg_s cfg_i,
  // filter data at end of conversion
  input  wire logic [23:0]       raw_data_i,
  // results
  output logic [23:0]            result_o,
  output logic                   result_ready_n_o,
  // status
  output logic                   conv_active_o,
  output logic                   config_error_o,
  output cas_pkg::cas_cfg_s      cfg_o,
  // analog front-end control
  output logic                   chop_swap_o,
  output logic                   ref_invert_o,
  // general pins
  output logic [3:0]             general_pin_o,
  output logic [3:0]             general_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // latency and period tables, microseconds, latencies with a 50 us wait included

  function automatic logic [21:0] pick(input logic [2:0] f,
                                       input logic [21:0] v0, input logic [21:0] v1,
                                       input logic [21:0] v2, input logic [21:0] v3,
                                       input logic [21:0] v4, input logic [21:0] v5);
    logic [21:0] r;
    r = 22'd0;
    case (f)
      3'h0:    r = v0;
      3'h1:    r = v1;
      3'h2:    r = v2;
      3'h3:    r = v3;
      3'h4:    r = v4;
      3'h5:    r = v5;
      default: r = 22'd0;
    endcase
    return r;
  endfunction

  // zero marks a combination the filter does not offer
  function automatic logic [21:0] latency_us(input logic [4:0] rate, input logic [2:0] f);
    logic [21:0] r;
    r = 22'd0;
    case (rate)
      5'h00:   r = pick(f, 22'd402200, 22'd400400, 22'd800400, 22'd1200000, 22'd1600000, 22'd0);
      5'h01:   r = pick(f, 22'd202200, 22'd200400, 22'd400400, 22'd600400, 22'd800400, 22'd0);
      5'h02:   r = pick(f, 22'd102200, 22'd100400, 22'd200400, 22'd300400, 22'd400400, 22'd0);
      5'h03:   r = pick(f, 22'd0, 22'd60430, 22'd120400, 22'd180400, 22'd240400, 22'd0);
      5'h04:   r = pick(f, 22'd52230, 22'd50430, 22'd100400, 22'd150400, 22'd200400, 22'd0);
      5'h05:   r = pick(f, 22'd0, 22'd20430, 22'd40430, 22'd60430, 22'd80430, 22'd0);
      5'h06:   r = pick(f, 22'd0, 22'd17090, 22'd33760, 22'd50430, 22'd67090, 22'd0);
      5'h07:   r = pick(f, 22'd0, 22'd10430, 22'd20430, 22'd30430, 22'd40430, 22'd0);
      5'h08:   r = pick(f, 22'd0, 22'd2925, 22'd5425, 22'd7925, 22'd10430, 22'd0);
      5'h09:   r = pick(f, 22'd0, 22'd1258, 22'd2091, 22'd2925, 22'd3758, 22'd0);
      5'h0A:   r = pick(f, 22'd0, 22'd841, 22'd1258, 22'd1675, 22'd2091, 22'd0);
      5'h0B:   r = pick(f, 22'd0, 22'd633, 22'd841, 22'd1050, 22'd1258, 22'd0);
      5'h0C:   r = pick(f, 22'd0, 22'd564, 22'd702, 22'd841, 22'd980, 22'd0);
      5'h0D:   r = pick(f, 22'd0, 22'd0, 22'd0, 22'd0, 22'd0, 22'd423);
      5'h0E:   r = pick(f, 22'd0, 22'd0, 22'd0, 22'd0, 22'd0, 22'd336);
      5'h0F:   r = pick(f, 22'd0, 22'd0, 22'd0, 22'd0, 22'd0, 22'd271);
      5'h10:   r = pick(f, 22'd0, 22'd0, 22'd0, 22'd0, 22'd0, 22'd179);
      default: r = 22'd0;
    endcase
    return r;
  endfunction

  // output data period 1/fdata
  function automatic logic [21:0] period_us(input logic [4:0] rate);
    logic [21:0] r;
    r = 22'd0;
    case (rate)
      5'h00:   r = 22'd400000;
      5'h01:   r = 22'd200000;
      5'h02:   r = 22'd100000;
      5'h03:   r = 22'd60241;
      5'h04:   r = 22'd50000;
      5'h05:   r = 22'd20000;
      5'h06:   r = 22'd16667;
      5'h07:   r = 22'd10000;
      5'h08:   r = 22'd2500;
      5'h09:   r = 22'd833;
      5'h0A:   r = 22'd417;
      5'h0B:   r = 22'd208;
      5'h0C:   r = 22'd139;
      5'h0D:   r = 22'd69;
      5'h0E:   r = 22'd52;
      5'h0F:   r = 22'd39;
      5'h10:   r = 22'd25;
      default: r = 22'd0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    cas_pkg::cas_state_e fsm;
    cas_pkg::cas_cfg_s   cfg;
    logic                start_s1;
    logic                start_s2;
    logic                start_d;
    logic [6:0]          us_div;
    logic [21:0]         us_cnt;
    logic [21:0]         target;
    logic                reversed;
    logic                withheld;
    logic                first_done;
    logic                rdy_n;
    logic [23:0]         prev;
    logic [23:0]         result;
  } cas_seq_s;

  cas_seq_s st;
  cas_seq_s next_st;

  logic        chopping;
  logic        acx_on;
  logic        us_tick;
  logic        start_rise;
  logic [21:0] lat_us;
  logic [21:0] wait_us;
  logic [21:0] first_us;
  logic [24:0] diff;
  logic        drive_a;
  logic        drive_b;

  assign chopping = (st.cfg.chop != `CAS_CHOP_OFF);
  assign acx_on   = st.cfg.chop[1];
  assign us_tick  = (st.us_div == 7'(`CAS_US_CYCLES - 1));
  assign start_rise = st.start_s2 && !st.start_d;
  assign lat_us   = latency_us(st.cfg.rate, st.cfg.filter);
  assign wait_us  = 22'(st.cfg.wait_code) * 22'(`CAS_WAIT_STEP_US);
  // table already holds a 50 us wait; swap it for the programmed one
  assign first_us = lat_us - 22'(`CAS_TABLE_WAIT_US) + wait_us;

  // full difference, normal phase minus reversed phase; halved when stored
  always_comb begin
    if (st.reversed) begin
      diff = {st.prev[23], st.prev} - {raw_data_i[23], raw_data_i};
    end else begin
      diff = {raw_data_i[23], raw_data_i} - {st.prev[23], st.prev};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_st          = st;
    next_st.start_s1 = start_pin_i;
    next_st.start_s2 = st.start_s1;
    next_st.start_d  = st.start_s2;
    next_st.us_div   = us_tick ? 7'h00 : st.us_div + 7'h01;

    if (cfg_load_i && (st.fsm == cas_pkg::CAS_IDLE)) begin
      next_st.cfg = cfg_i;
    end

    if (start_rise && !config_error_o) begin
      // start or restart: normal phase, fresh operand
      next_st.fsm        = cas_pkg::CAS_RUN;
      next_st.us_div     = 7'h00;
      next_st.us_cnt     = 22'h000000;
      next_st.target     = first_us;
      next_st.reversed   = 1'b0;
      next_st.withheld   = chopping;
      next_st.first_done = 1'b0;
      next_st.rdy_n      = 1'b1;
    end else if ((st.fsm == cas_pkg::CAS_RUN) && us_tick) begin
      next_st.us_cnt = st.us_cnt + 22'h000001;
      if (st.rdy_n == 1'b0 && st.first_done) begin
        next_st.rdy_n = 1'b1;
      end
      if (st.us_cnt + 22'h000001 >= st.target) begin
        next_st.us_cnt     = 22'h000000;
        next_st.first_done = 1'b1;
        if (chopping) begin
          next_st.prev     = raw_data_i;
          next_st.reversed = ~st.reversed;
          next_st.withheld = 1'b0;
          // each later conversion takes the chop-off latency
          next_st.target   = first_us;
          if (!st.withheld) begin
            next_st.result = diff[24:1];
            next_st.rdy_n  = 1'b0;
          end
        end else begin
          next_st.result = raw_data_i;
          next_st.rdy_n  = 1'b0;
          next_st.target = period_us(st.cfg.rate);
        end
        // continuous runs while the pin stays high; withheld one always completes
        if (!((st.cfg.continuous && st.start_s2) || (chopping && st.withheld))) begin
          next_st.fsm = cas_pkg::CAS_IDLE;
        end
      end
    end

    if (st.fsm == cas_pkg::CAS_IDLE) begin
      next_st.reversed = (start_rise && !config_error_o) ? 1'b0 : st.reversed;
    end

    // synchronous reset folded in here so the register stays one plain copy
    if (sys_rst_i) begin
      next_st                = '0;
      next_st.fsm            = cas_pkg::CAS_IDLE;
      next_st.cfg.rate       = `CAS_RATE_RST;
      next_st.cfg.filter     = `CAS_FILT_RST;
      next_st.cfg.chop       = `CAS_CHOP_OFF;
      next_st.cfg.wait_code  = `CAS_WAIT_RST_CODE;
      next_st.cfg.continuous = 1'b1;
      next_st.rdy_n          = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // excitation drives and pins

  cas_excite_drive u_drive (
    .sys_clk_i        (sys_clk_i),
    .sys_rst_i        (sys_rst_i),
    .enable_i         (acx_on && (st.fsm == cas_pkg::CAS_RUN)),
    .reversed_i       (st.reversed),
    .excite_drive_a_o (drive_a),
    .excite_drive_b_o (drive_b)
  );

  cas_pkg::cas_gpio_s gpio;

  always_comb begin
    gpio = '0;
    if (st.cfg.chop == `CAS_ACX_2WIRE) begin
      gpio.level  = {2'b00, drive_b, drive_a};
      gpio.enable = 4'h3;
    end else if (st.cfg.chop == `CAS_ACX_4WIRE) begin
      gpio.level  = {drive_b, drive_a, drive_b, drive_a};
      gpio.enable = 4'hF;
    end
  end

  assign general_pin_o    = gpio.level;
  assign general_pin_oe_o = gpio.enable;
  assign result_o         = st.result;
  assign result_ready_n_o = st.rdy_n;
  assign conv_active_o    = (st.fsm == cas_pkg::CAS_RUN);
  assign config_error_o   = (lat_us == 22'h000000) || (st.cfg.rate >= 5'(`CAS_RATE_CODES));
  assign cfg_o            = st.cfg;
  assign chop_swap_o      = (st.cfg.chop == `CAS_CHOP_ON) && st.reversed;
  assign ref_invert_o     = acx_on && st.reversed;

endmodule // cas_conv_seq

/* cas_conv_seq_props.sv */
// assertions on the conversion sequencer ports
`timescale 1ns/1ps
module cas_conv_seq_props (
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  // inputs
  input wire logic              start_pin_i,
  input wire logic              cfg_load_i,
  input wire cas_pkg::cas_cfg_s cfg_i,
  input wire logic [23:0]       raw_data_i,
  // outputs
  input wire logic [23:0]       result_o,
  input wire logic              result_ready_n_o,
  input wire logic              conv_active_o,
  input wire logic              config_error_o,
  input wire cas_pkg::cas_cfg_s cfg_o,
  input wire logic              chop_swap_o,
  input wire logic              ref_invert_o,
  input wire logic [3:0]        general_pin_o,
  input wire logic [3:0]        general_pin_oe_o
);
  logic [7:0] gap_cnt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // saturates so a long idle never wraps into a short gap
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || general_pin_o[1:0] != 2'h0) begin
      gap_cnt <= 8'h00;
    end else if (gap_cnt != 8'hFF) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  no_overlap_a: assert property (
    !(general_pin_o[0] && general_pin_o[1])) else $error("drives overlap");
  gap_before_b_a: assert property (
    $rose(general_pin_o[1]) |-> gap_cnt >= 8'h63) else $error("gap too short");
  four_wire_copy_a: assert property (
    cfg_o.chop == 2'h3 |-> general_pin_o[3:2] == general_pin_o[1:0])
    else $error("upper pins differ");
  two_wire_upper_a: assert property (
    cfg_o.chop == 2'h2 |-> general_pin_oe_o[3:2] == 2'h0 && general_pin_o[3:2] == 2'h0)
    else $error("upper pins driven");
  drives_idle_a: assert property (
    !cfg_o.chop[1] |-> general_pin_o == 4'h0 && general_pin_oe_o == 4'h0)
    else $error("drives without excitation");
  drive_phase_a: assert property (
    general_pin_o[1:0] != 2'h0 |-> $past(ref_invert_o) == general_pin_o[1])
    else $error("drive and phase differ");
  swap_chop_only_a: assert property (
    chop_swap_o |-> cfg_o.chop == 2'h1) else $error("swap outside chop");
  start_normal_a: assert property (
    $rose(conv_active_o) |-> result_ready_n_o && !chop_swap_o && !ref_invert_o)
    else $error("bad state at start");
  ready_stands_a: assert property (
    $fell(result_ready_n_o) |=> !result_ready_n_o [*8]) else $error("ready too short");
  drive_hold_a: assert property (
    $changed(general_pin_o[1:0]) |=> $stable(general_pin_o[1:0]) [*8])
    else $error("drives toggle fast");
  chop_result_c: cover property ($fell(result_ready_n_o) && cfg_o.chop == 2'h1);
  acx_result_c: cover property ($fell(result_ready_n_o) && cfg_o.chop == 2'h3);
  drive_b_c: cover property ($rose(general_pin_o[1]));
endmodule // cas_conv_seq_props

bind cas_conv_seq cas_conv_seq_props u_props (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .start_pin_i(start_pin_i),
  .cfg_load_i(cfg_load_i), .cfg_i(cfg_i), .raw_data_i(raw_data_i), .result_o(result_o),
  .result_ready_n_o(result_ready_n_o), .conv_active_o(conv_active_o),
  .config_error_o(config_error_o), .cfg_o(cfg_o), .chop_swap_o(chop_swap_o),
  .ref_invert_o(ref_invert_o), .general_pin_o(general_pin_o),
  .general_pin_oe_o(general_pin_oe_o));

/* cas_bridge_model.sv */
// bridge and front-end model feeding filter data to the sequencer
`timescale 1ns/1ps
module cas_bridge_model (
  // phase controls
  input  wire logic        chop_swap_i,
  input  wire logic        ref_invert_i,
  // bridge signal and input offset
  input  wire logic [23:0] level_i,
  input  wire logic [23:0] offset_i,
  // filter output
  output logic [23:0]      raw_data_o
);
  // no external settling modelled, so a zero start wait is enough here
  assign raw_data_o = (chop_swap_i || ref_invert_i) ? offset_i - level_i
                                                    : offset_i + level_i;
endmodule // cas_bridge_model

/* tb_chop_acx_conversion_sequencer.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_chop_acx_conversion_sequencer;
  logic              sys_clk_i;
  logic              sys_rst_i;
  logic              start_pin_i;
  logic              cfg_load_i;
  cas_pkg::cas_cfg_s cfg_i;
  cas_pkg::cas_cfg_s cfg_o;
  logic [23:0]       raw_data_i;
  logic [23:0]       result_o;
  logic              result_ready_n_o;
  logic              conv_active_o;
  logic              config_error_o;
  logic              chop_swap_o;
  logic              ref_invert_o;
  logic [3:0]        general_pin_o;
  logic [3:0]        general_pin_oe_o;
  logic [23:0]       level;
  logic [23:0]       offset;
  int                errors;
  int                checked;
  int                conv_q[$];

  cas_conv_seq uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .start_pin_i(start_pin_i), .cfg_load_i(cfg_load_i), .cfg_i(cfg_i),
    .raw_data_i(raw_data_i), .result_o(result_o), .result_ready_n_o(result_ready_n_o),
    .conv_active_o(conv_active_o), .config_error_o(config_error_o), .cfg_o(cfg_o),
    .chop_swap_o(chop_swap_o), .ref_invert_o(ref_invert_o),
    .general_pin_o(general_pin_o), .general_pin_oe_o(general_pin_oe_o));
  cas_bridge_model u_bridge (.chop_swap_i(chop_swap_o), .ref_invert_i(ref_invert_o),
    .level_i(level), .offset_i(offset), .raw_data_o(raw_data_i));

  always #5 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // plain conversion, or half of normal minus reversed phase
  function automatic logic [31:0] model_result(input int paired);
    conv_q = {};
    conv_q.push_back($signed(offset) + $signed(level));
    conv_q.push_back($signed(offset) - $signed(level));
    return {8'h00, 24'(paired ? (conv_q[0] - conv_q[1]) / 2 : conv_q[0])};
  endfunction

  task automatic do_reset();
    sys_rst_i = 1'b1;
    start_pin_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic load_cfg(input logic [1:0] chop, input logic [3:0] wcode, input logic cont);
    cfg_i = '{rate: 5'h10, filter: 3'h5, chop: chop, wait_code: wcode, continuous: cont};
    cfg_load_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_load_i = 1'b0;
    @(negedge sys_clk_i);
    check("cfg_chop", {30'h0, cfg_o.chop}, {30'h0, chop});
    check("cfg_error", {31'h0, config_error_o}, 32'h0);
  endtask

  // earlier results are discarded: only settled data is compared
  task automatic wait_ready(input string name, input int exp);
    int   n;
    logic armed;
    n = 0;
    armed = result_ready_n_o;
    while (!(armed && result_ready_n_o === 1'b0) && n < exp + 50) begin
      @(negedge sys_clk_i);
      n++;
      if (result_ready_n_o === 1'b1) armed = 1'b1;
    end
    if (n >= exp + 50) begin
      errors++;
      $display("unexpected %s: expected %0d seen timeout", name, exp);
      summarize();
    end else begin
      check(name, 32'(n >= exp - 6 && n <= exp + 6), 32'h1);
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    cfg_load_i = 1'b0;
    cfg_i = '0;
    errors = 0;
    checked = 0;
    void'($urandom(65312));
    level = 24'($urandom % 32'h100000);
    offset = 24'($urandom % 32'h80000) - 24'h040000;
    do_reset();
    check("cfg_reset", {17'h0, cfg_o}, {17'h0, 5'h00, 3'h1, 2'h0, 4'h1, 1'b1});
    load_cfg(2'h0, 4'h1, 1'b0);
    start_pin_i = 1'b1;
    wait_ready("plain_latency", 17900);
    check("plain_result", {8'h00, result_o}, model_result(0));
    check("pulse_idle", {31'h0, conv_active_o}, 32'h0);
    $display("test pulse done");
    do_reset();
    load_cfg(2'h1, 4'h0, 1'b1);
    start_pin_i = 1'b1;
    wait_ready("chop_first", 25800);
    check("chop_first", {8'h00, result_o}, model_result(1));
    wait_ready("chop_next", 12900);
    check("chop_next", {8'h00, result_o}, model_result(1));
    $display("test chop done");
    do_reset();
    load_cfg(2'h2, 4'h0, 1'b1);
    start_pin_i = 1'b1;
    repeat (3000) @(negedge sys_clk_i);
    check("two_wire_oe", {28'h0, general_pin_oe_o}, 32'h3);
    check("two_wire_pins", {28'h0, general_pin_o}, 32'h1);
    $display("test two-wire done");
    do_reset();
    load_cfg(2'h3, 4'h0, 1'b1);
    start_pin_i = 1'b1;
    wait_ready("acx_first", 25800);
    check("acx_result", {8'h00, result_o}, model_result(1));
    check("four_wire_oe", {28'h0, general_pin_oe_o}, 32'hF);
    // third conversion is normal phase again: A on pins 0 and 2 once the gap ends
    repeat (200) @(negedge sys_clk_i);
    check("four_wire_copy", {28'h0, general_pin_o}, 32'h5);
    check("acx_ref_normal", {31'h0, ref_invert_o}, 32'h0);
    $display("test four-wire done");
    summarize();
  end
endmodule // tb_chop_acx_conversion_sequencer
